/* File: shared/acr_pkg.sv */
// constants of the converter configuration register bank
// assumes a three-wire serial port and one system clock for the bank
// Operation
// - every implemented register reads 0x00 after any reset
// - writing one to bit 1 of 0x00 clears all registers, bit self-clears
// - bit 0 of 0x00 picks over-range flag or register echo on the pin
// - bits 7:2 of 0x01 hold the output amplitude code
// - amplitude code applies only when its enable field is set
// - bits 7:4 of 0x25 give gain 0 to 3.5 dB, low codes forbidden
// - bits 2:0 of 0x25: normal data, all zeros or all ones
// - code 011 alternates a 0101 word and its complement every sample
// - code 100 ramps: wide by one each clock, narrow every fourth clock
// - code 101 outputs the user word from 0x3F and 0x40
// - 0x26 bit 1 clock driver, bit 0 data driver strength
// - 0x3D bits 7:6: pin decides, twos complement or offset binary
// - 0x3D bit 5 enables the offset correction loop
// - one write updates every field of a register together
// - 16-bit frames, address then data, falling edges, select low
// - echo mode blocks writes except to 0x00 and shifts data out

package acr_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int NUM_REGS = 15;
    localparam logic [7:0] REG_ADDR [NUM_REGS] = '{
        8'h00, 8'h01, 8'h03, 8'h25, 8'h26, 8'h3D, 8'h3F, 8'h40,
        8'h41, 8'h42, 8'h43, 8'h4A, 8'hBF, 8'hCF, 8'hDF};
    // writable bits; reserved bits are held at zero
    localparam logic [7:0] REG_MASK [NUM_REGS] = '{
        8'h03, 8'hFC, 8'h03, 8'hF7, 8'h03, 8'hE0, 8'h3F, 8'hFF,
        8'hFF, 8'hC4, 8'h53, 8'h01, 8'hFC, 8'hBC, 8'h30};
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int IDX_CTRL = 0;
    localparam int IDX_AMP = 1;
    localparam int IDX_PERF1 = 2;
    localparam int IDX_GAIN = 3;
    localparam int IDX_DRV = 4;
    localparam int IDX_FMT = 5;
    localparam int IDX_UHI = 6;
    localparam int IDX_ULO = 7;
    localparam int IDX_IF = 8;
    localparam int IDX_FALL = 9;
    localparam int IDX_PDN = 10;
    localparam int IDX_PERF2 = 11;
    localparam int IDX_PED = 12;
    localparam int IDX_OLOOP = 13;
    localparam int IDX_SLOW = 14;

    // ------------------------------------------------------------
    // field positions and codes
    // ------------------------------------------------------------
    localparam int BIT_ECHO = 0;
    localparam int BIT_SOFT_RST = 1;
    localparam int BIT_OFS_EN = 5;
    localparam logic [1:0] SWING_EN_CODE = 2'h3;
    localparam logic [3:0] GAIN_MIN_CODE = 4'h5;
    localparam logic [1:0] FMT_TWOS = 2'h2;
    localparam logic [1:0] FMT_OFFSET = 2'h3;
    localparam logic [2:0] PAT_NORMAL = 3'h0;
    localparam logic [2:0] PAT_ZEROS = 3'h1;
    localparam logic [2:0] PAT_ONES = 3'h2;
    localparam logic [2:0] PAT_TOGGLE = 3'h3;
    localparam logic [2:0] PAT_RAMP = 3'h4;
    localparam logic [2:0] PAT_CUSTOM = 3'h5;
    localparam logic [13:0] TOGGLE_WIDE = 14'h1555;
    localparam logic [13:0] TOGGLE_NARROW = 14'h0555;
    localparam logic [13:0] NARROW_MASK = 14'h0FFF;
    localparam logic [1:0] RAMP_NARROW_LAST = 2'h3;
    localparam logic [3:0] FRAME_LAST_BIT = 4'hF;
    localparam logic [3:0] ADDR_LAST_BIT = 4'h7;

endpackage : acr_pkg

/* File: rtl/acr_serial_link.sv */
// serial frame receiver and register echo shifter, shift clock domain
// assumes select low frames the transfer and a clear pulse from the system
`timescale 1ns/1ps

module acr_serial_link
    import acr_pkg::*;
(
    input wire logic shift_clk,
    input wire logic link_clear,
    input wire logic serial_select_n,
    input wire logic serial_input_line,
    input wire logic [7:0] read_data,
    output logic [7:0] read_addr,
    output logic [15:0] word_out,
    output logic word_toggle,
    output logic echo_bit
);

    logic [3:0] cnt_r;
    logic [14:0] shift_r;
    logic [7:0] echo_r;
    logic [15:0] frame_nxt;
    logic last_bit;
    logic addr_done;

    // ------------------------------------------------------------
    // frame decode
    // ------------------------------------------------------------
    assign frame_nxt = {shift_r, serial_input_line};
    assign last_bit = (cnt_r == FRAME_LAST_BIT);
    assign addr_done = (cnt_r == ADDR_LAST_BIT);
    assign read_addr = frame_nxt[7:0];
    assign echo_bit = echo_r[7];

    // bit counter; select high restarts the frame, partial words are lost
    always_ff @(negedge shift_clk or posedge serial_select_n) begin
        if (serial_select_n) begin
            cnt_r <= 4'h0;
            shift_r <= 15'h0000;
        end else begin
            cnt_r <= cnt_r + 4'h1;
            shift_r <= frame_nxt[14:0];
        end
    end

    // echo shifter: loads after the address byte, msb first
    always_ff @(negedge shift_clk or posedge serial_select_n) begin
        if (serial_select_n) begin
            echo_r <= 8'h00;
        end else if (addr_done) begin
            echo_r <= read_data;
        end else begin
            echo_r <= {echo_r[6:0], 1'b0};
        end
    end

    // word holds still for 16 shift periods, long enough for the toggle
    always_ff @(negedge shift_clk or posedge link_clear) begin
        if (link_clear) begin
            word_out <= 16'h0000;
            word_toggle <= 1'b0;
        end else if (last_bit && !serial_select_n) begin
            word_out <= frame_nxt;
            word_toggle <= ~word_toggle;
        end
    end

endmodule : acr_serial_link

/* File: rtl/acr_register_bank.sv */
// configuration register bank and output word selector of the converter
// assumes ref_clk is the sample clock and the serial port runs on shift_clk
`timescale 1ns/1ps

module acr_register_bank
    import acr_pkg::*;
#(
    parameter logic WIDE_VARIANT = 1'b1
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic shift_clk,
    input wire logic serial_select_n,
    input wire logic serial_input_line,
    input wire logic format_select_pin,
    input wire logic over_range,
    input wire logic [13:0] conv_data,
    output logic overload_or_echo_pin,
    output logic [13:0] data_out,
    output logic [3:0] gain_code,
    output logic [5:0] swing_code,
    output logic clock_driver_strength,
    output logic data_driver_strength,
    output logic offset_loop_enable,
    output logic twos_complement,
    output logic [1:0] performance_boost_a,
    output logic performance_boost_b,
    output logic [7:0] iface_cfg,
    output logic [7:0] clk_fall_cfg,
    output logic [7:0] power_cfg,
    output logic [7:0] pedestal_cfg,
    output logic [7:0] loop_cfg,
    output logic [7:0] slow_cfg
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0] bank_r [NUM_REGS];
    logic [NUM_REGS-1:0] hit;
    logic link_clear_r;
    logic [7:0] read_addr;
    logic [7:0] read_data;
    logic [15:0] link_word;
    logic link_toggle;
    logic link_echo;
    logic tog_s1_r, tog_s2_r, tog_s3_r;
    logic echo_s1_r, echo_s2_r, echo_s3_r;
    logic fmt_s1_r, fmt_s2_r, fmt_s3_r, fmt_pin_r;
    logic soft_clr_r;
    logic wr_fire;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic echo_mode;
    logic [2:0] pattern;
    logic [3:0] gain_field;
    logic [1:0] fmt_field;
    logic twos_sel;
    logic phase_r;
    logic [13:0] ramp_r;
    logic [13:0] ramp_nxt;
    logic [1:0] pre_r;
    logic [13:0] custom_word;
    logic [13:0] toggle_word;
    logic [13:0] conv_fmt;
    logic [13:0] width_mask;
    logic [13:0] data_nxt;

    // ------------------------------------------------------------
    // serial port in the shift clock domain
    // ------------------------------------------------------------
    acr_serial_link u_link (
        .shift_clk(shift_clk),
        .link_clear(link_clear_r),
        .serial_select_n(serial_select_n),
        .serial_input_line(serial_input_line),
        .read_data(read_data),
        .read_addr(read_addr),
        .word_out(link_word),
        .word_toggle(link_toggle),
        .echo_bit(link_echo)
    );

    // echo source: bank is frozen in echo mode, so the mux is quasi-static
    always_comb begin
        read_data = REG_RESET;
        for (int i = 1; i < NUM_REGS; i++) begin
            if (read_addr == REG_ADDR[i]) begin
                read_data = bank_r[i];
            end
        end
    end

    // ------------------------------------------------------------
    // crossings into ref_clk
    // ------------------------------------------------------------
    // link clear is registered so the far side sees a clean level
    always_ff @(posedge ref_clk) begin
        link_clear_r <= reset;
        if (reset) begin
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
            tog_s3_r <= 1'b0;
            echo_s1_r <= 1'b0;
            echo_s2_r <= 1'b0;
            echo_s3_r <= 1'b0;
        end else begin
            tog_s1_r <= link_toggle;
            tog_s2_r <= tog_s1_r;
            tog_s3_r <= tog_s2_r;
            echo_s1_r <= link_echo;
            echo_s2_r <= echo_s1_r;
            echo_s3_r <= echo_s2_r;
        end
    end

    // format pin: three stages, a change counts once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fmt_s1_r <= 1'b0;
            fmt_s2_r <= 1'b0;
            fmt_s3_r <= 1'b0;
            fmt_pin_r <= 1'b0;
        end else begin
            fmt_s1_r <= format_select_pin;
            fmt_s2_r <= fmt_s1_r;
            fmt_s3_r <= fmt_s2_r;
            if (fmt_s2_r == fmt_s3_r) begin
                fmt_pin_r <= fmt_s3_r;
            end
        end
    end

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    // word is stable for many cycles after its toggle edge
    assign wr_fire = tog_s2_r ^ tog_s3_r;
    assign wr_addr = link_word[15:8];
    assign wr_data = link_word[7:0];
    assign echo_mode = bank_r[IDX_CTRL][BIT_ECHO];

    // one entry per register; unlisted addresses match nothing
    generate
        for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
            assign hit[g] = wr_fire && (wr_addr == REG_ADDR[g])
                            && ((g == IDX_CTRL) || !echo_mode);
            always_ff @(posedge ref_clk) begin
                if (reset || soft_clr_r) begin
                    bank_r[g] <= REG_RESET;
                end else if (hit[g]) begin
                    bank_r[g] <= wr_data & REG_MASK[g];
                end
            end
        end
    endgenerate

    // reset bit is seen set for one cycle, then the whole bank clears
    always_ff @(posedge ref_clk) begin
        if (reset || soft_clr_r) begin
            soft_clr_r <= 1'b0;
        end else begin
            soft_clr_r <= hit[IDX_CTRL] && wr_data[BIT_SOFT_RST];
        end
    end

    // ------------------------------------------------------------
    // output word selection
    // ------------------------------------------------------------
    assign pattern = bank_r[IDX_GAIN][2:0];
    assign gain_field = bank_r[IDX_GAIN][7:4];
    assign fmt_field = bank_r[IDX_FMT][7:6];
    // converter words are offset binary; pin low asks for twos complement
    assign twos_sel = (fmt_field == FMT_TWOS) ? 1'b1 :
                      (fmt_field == FMT_OFFSET) ? 1'b0 : !fmt_pin_r;
    assign width_mask = WIDE_VARIANT ? 14'h3FFF : NARROW_MASK;
    assign conv_fmt = WIDE_VARIANT ? {conv_data[13] ^ twos_sel, conv_data[12:0]}
                    : {2'h0, conv_data[13] ^ twos_sel, conv_data[12:2]};
    assign toggle_word = (WIDE_VARIANT ? TOGGLE_WIDE : TOGGLE_NARROW)
                         ^ (phase_r ? width_mask : 14'h0000);
    assign custom_word = WIDE_VARIANT
                       ? {bank_r[IDX_UHI][5:0], bank_r[IDX_ULO]}
                       : {2'h0, bank_r[IDX_UHI][5:0], bank_r[IDX_ULO][7:2]};
    // narrow ramp only steps on every fourth clock and wraps at 4095
    assign ramp_nxt = WIDE_VARIANT ? ramp_r + 14'h0001
                    : (pre_r == RAMP_NARROW_LAST)
                      ? ((ramp_r + 14'h0001) & NARROW_MASK) : ramp_r;
    // unused codes fall back to normal data
    assign data_nxt = (pattern == PAT_ZEROS) ? 14'h0000 :
                      (pattern == PAT_ONES) ? width_mask :
                      (pattern == PAT_TOGGLE) ? toggle_word :
                      (pattern == PAT_RAMP) ? ramp_r :
                      (pattern == PAT_CUSTOM) ? custom_word : conv_fmt;

    // pattern generators run freely so a mode change starts mid-sequence
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            phase_r <= 1'b0;
            ramp_r <= 14'h0000;
            pre_r <= 2'h0;
        end else begin
            phase_r <= ~phase_r;
            ramp_r <= ramp_nxt;
            pre_r <= pre_r + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            overload_or_echo_pin <= 1'b0;
            data_out <= 14'h0000;
            gain_code <= GAIN_MIN_CODE;
            swing_code <= 6'h00;
            clock_driver_strength <= 1'b0;
            data_driver_strength <= 1'b0;
            offset_loop_enable <= 1'b0;
            twos_complement <= 1'b0;
            performance_boost_a <= 2'h0;
            performance_boost_b <= 1'b0;
        end else begin
            // echo bit only moves once stages two and three agree
            overload_or_echo_pin <= !echo_mode ? over_range :
                                    (echo_s2_r == echo_s3_r) ? echo_s3_r : overload_or_echo_pin;
            data_out <= data_nxt;
            // forbidden low gain codes behave as 0 dB
            gain_code <= (gain_field < GAIN_MIN_CODE) ? GAIN_MIN_CODE
                       : gain_field;
            swing_code <= (bank_r[IDX_PDN][1:0] == SWING_EN_CODE)
                        ? bank_r[IDX_AMP][7:2] : 6'h00;
            clock_driver_strength <= bank_r[IDX_DRV][1];
            data_driver_strength <= bank_r[IDX_DRV][0];
            offset_loop_enable <= bank_r[IDX_FMT][BIT_OFS_EN];
            twos_complement <= twos_sel;
            performance_boost_a <= bank_r[IDX_PERF1][1:0];
            performance_boost_b <= bank_r[IDX_PERF2][0];
        end
    end

    // raw configuration bytes for the interface and power logic
    always_ff @(posedge ref_clk) begin
        iface_cfg <= bank_r[IDX_IF];
        clk_fall_cfg <= bank_r[IDX_FALL];
        power_cfg <= bank_r[IDX_PDN];
        pedestal_cfg <= bank_r[IDX_PED];
        loop_cfg <= bank_r[IDX_OLOOP];
        slow_cfg <= bank_r[IDX_SLOW];
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_reset_zeroes: assert property (@(posedge ref_clk) disable iff (1'b0)
        reset |=> (bank_r[IDX_CTRL] == 8'h00) && (bank_r[IDX_ULO] == 8'h00)
                  && (bank_r[IDX_SLOW] == 8'h00))
        else $error("bank not cleared by reset");
    a_soft_reset_clears: assert property (
        (hit[IDX_CTRL] && wr_data[BIT_SOFT_RST]) |=> bank_r[IDX_CTRL][1]
        ##1 ((bank_r[IDX_CTRL] == 8'h00) && (bank_r[IDX_AMP] == 8'h00)))
        else $error("soft reset did not clear and self-clear");
    a_echo_pin_source: assert property (
        (!echo_mode && !wr_fire) |=> (overload_or_echo_pin == $past(over_range)))
        else $error("pin not showing over-range flag");
    a_swing_gate: assert property (
        (bank_r[IDX_PDN][1:0] != SWING_EN_CODE) |=> (swing_code == 6'h00))
        else $error("amplitude applied without enable");
    a_gain_floor: assert property (
        (gain_field < GAIN_MIN_CODE) |=> (gain_code == GAIN_MIN_CODE))
        else $error("forbidden gain code passed through");
    a_fixed_zero: assert property (
        (pattern == PAT_ZEROS) |=> (data_out == 14'h0000))
        else $error("all-zero pattern wrong");
    a_toggle_alt: assert property (
        (pattern == PAT_TOGGLE) [*2] |=> (data_out == (~$past(data_out) & width_mask)))
        else $error("toggle pattern not alternating");
    a_ramp_step: assert property (
        (WIDE_VARIANT && (pattern == PAT_RAMP)) [*2]
        |=> (data_out == $past(data_out) + 14'h0001))
        else $error("ramp did not step by one");
    a_echo_blocks: assert property (
        (echo_mode && wr_fire && (wr_addr != REG_ADDR[IDX_CTRL]))
        |=> $stable(bank_r[IDX_ULO]) && $stable(bank_r[IDX_GAIN]))
        else $error("write accepted in echo mode");
    a_unmapped_ignored: assert property (
        (wr_fire && (hit == '0)) |=> $stable(bank_r[IDX_FMT]) && $stable(bank_r[IDX_DRV]))
        else $error("unlisted address disturbed the bank");
    a_whole_write: assert property (
        (hit[IDX_GAIN] && !soft_clr_r) |=> (bank_r[IDX_GAIN] == $past(wr_data & 8'hF7)))
        else $error("register not written as one unit");

    c_write_gain: cover property (hit[IDX_GAIN]);
    c_echo_mode: cover property (echo_mode && wr_fire);
    c_soft_reset: cover property (soft_clr_r);
    c_custom_out: cover property (pattern == PAT_CUSTOM ##1 pattern == PAT_CUSTOM);

endmodule : acr_register_bank

/* File: testbench/acr_serial_ctrl.sv */
// controller model for the serial configuration port
// assumes the bench calls frame() and judges the echoed byte itself
`timescale 1ns/1ps

module acr_serial_ctrl (
    output logic shift_clk,
    output logic serial_select_n,
    output logic serial_input_line,
    input wire logic overload_or_echo_pin
);
    // ------------------------------------------------------------
    // idle link: clock parked low, port deselected
    // ------------------------------------------------------------
    initial begin
        shift_clk = 1'b0;
        serial_select_n = 1'b1;
        serial_input_line = 1'b1;
    end

    // one frame, msb first; half sets the pace, echo latched on edges 9 to 16
    task automatic frame(input logic [31:0] bits, input int nbits, input int half,
        output logic [7:0] echo);
        echo = 8'h00;
        serial_select_n = 1'b0;
        #25;
        // data moves on the rising edge so it never races the falling one
        for (int i = 0; i < nbits; i++) begin
            #(half) shift_clk = 1'b1;
            serial_input_line = bits[31-i];
            #(half);
            if (i >= 8 && i < 16) begin
                echo = {echo[6:0], overload_or_echo_pin};
            end
            shift_clk = 1'b0;
        end
        #25;
        serial_select_n = 1'b1;
        // released line flips so a stale bit never passes for a driven one
        serial_input_line = ~serial_input_line;
    endtask : frame

endmodule : acr_serial_ctrl

/* File: testbench/adc_config_register_bank_bench.sv */
// self-checking bench for the converter configuration register bank
// assumes the controller model drives the serial port at 12 ns or slower
`timescale 1ns/1ps

module adc_config_register_bank_bench
    import acr_pkg::*;
;
    logic ref_clk, reset, format_select_pin, over_range;
    logic [13:0] conv_data;
    logic shift_clk, serial_select_n, serial_input_line, overload_or_echo_pin;
    logic clock_driver_strength, data_driver_strength, offset_loop_enable;
    logic twos_complement, performance_boost_b;
    logic [13:0] data_out;
    logic [3:0] gain_code;
    logic [5:0] swing_code;
    logic [1:0] performance_boost_a;
    logic [7:0] iface_cfg, clk_fall_cfg, power_cfg, pedestal_cfg, loop_cfg, slow_cfg;
    logic [7:0] rd;
    logic [13:0] s0, s1;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    // bundles keep the comparisons short
    wire [11:0] misc = {swing_code, clock_driver_strength, data_driver_strength,
        offset_loop_enable, performance_boost_a, performance_boost_b};
    wire [47:0] cfgs = {iface_cfg, clk_fall_cfg, power_cfg, pedestal_cfg, loop_cfg, slow_cfg};
    wire [15:0] fmt = {twos_complement, offset_loop_enable, data_out};
    wire [1:0] drv = {clock_driver_strength, data_driver_strength};

    acr_register_bank #(.WIDE_VARIANT(1'b1)) acr_register_bank_i (
        .ref_clk, .reset, .shift_clk, .serial_select_n, .serial_input_line,
        .format_select_pin, .over_range, .conv_data, .overload_or_echo_pin, .data_out,
        .gain_code, .swing_code, .clock_driver_strength, .data_driver_strength,
        .offset_loop_enable, .twos_complement, .performance_boost_a, .performance_boost_b,
        .iface_cfg, .clk_fall_cfg, .power_cfg, .pedestal_cfg, .loop_cfg, .slow_cfg);
    acr_serial_ctrl acr_serial_ctrl_i (
        .shift_clk, .serial_select_n, .serial_input_line, .overload_or_echo_pin);

    // ------------------------------------------------------------
    // harness
    // ------------------------------------------------------------
    // sample clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // a hang costs a mismatch; the real run needs about 1700 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            give_verdict;
        end
    end
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // fast write; eight cycles cover the 3 to 4 cycle crossing
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acr_serial_ctrl_i.frame({a, d, 16'h0000}, 16, 6, rd);
        repeat (8) @(posedge ref_clk);
    endtask : wr
    // slow frame so each echo bit crosses before the controller latches it
    task automatic rdr(input logic [7:0] a);
        acr_serial_ctrl_i.frame({a, 24'h000000}, 16, 30, rd);
        repeat (8) @(posedge ref_clk);
    endtask : rdr
    task automatic pins(input logic f, input logic o);
        @(posedge ref_clk);
        format_select_pin <= f;
        over_range <= o;
        repeat (8) @(posedge ref_clk);
    endtask : pins
    task automatic grab;
        @(posedge ref_clk);
        #1 s0 = data_out;
        @(posedge ref_clk);
        #1 s1 = data_out;
    endtask : grab
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        check("gain", gain_code, 4'h5);
        check("misc", misc, 12'h000);
        check("cfg", cfgs, 48'h0);
        check("fmt", fmt, {2'b00, 14'h1234});
        $display("test reset done");
    endtask : t_reset
    task automatic t_patterns;
        wr(8'h3F, 8'h2A);
        wr(8'h40, 8'h5C);
        wr(8'h25, {4'hC, 1'b0, PAT_CUSTOM});
        check("gain", gain_code, 4'hC);
        check("custom", data_out, {6'h2A, 8'h5C});
        wr(8'h25, {4'h2, 1'b0, PAT_ZEROS});
        check("gain low", gain_code, 4'h5);
        check("zeros", data_out, 14'h0000);
        wr(8'h25, {4'h5, 1'b0, PAT_ONES});
        check("ones", data_out, 14'h3FFF);
        wr(8'h25, {4'h5, 1'b0, PAT_TOGGLE});
        grab;
        check("toggle", s0 ^ s1, 14'h3FFF);
        check("toggle word", (s0 == 14'h1555 || s0 == 14'h2AAA), 1'b1);
        wr(8'h25, {4'h5, 1'b0, PAT_RAMP});
        grab;
        check("ramp", s1, s0 + 14'h0001);
        wr(8'h25, 8'h56);
        check("unused code", data_out, 14'h1234);
        wr(8'h25, 8'h50);
        $display("output_source_select done");
    endtask : t_patterns
    task automatic t_format;
        wr(8'h26, 8'h02);
        check("strength", drv, 2'b10);
        wr(8'h3D, 8'hA0);
        check("twos", fmt, {2'b11, 14'h3234});
        wr(8'h3D, 8'hC0);
        check("offset bin", fmt, {2'b00, 14'h1234});
        wr(8'h3D, 8'h00);
        pins(1'b0, 1'b0);
        check("pin format", twos_complement, 1'b1);
        pins(1'b1, 1'b0);
        wr(8'h26, 8'h01);
        check("strength", drv, 2'b01);
        $display("test format done");
    endtask : t_format
    task automatic t_swing;
        wr(8'h01, 8'h6C);
        check("swing off", swing_code, 6'h00);
        wr(8'h43, 8'h03);
        check("swing on", {swing_code, power_cfg}, {6'h1B, 8'h03});
        wr(8'h01, 8'h50);
        check("swing max", swing_code, 6'h14);
        wr(8'h43, 8'h00);
        $display("test swing done");
    endtask : t_swing
    task automatic t_multi;
        acr_serial_ctrl_i.frame({8'h03, 8'h03, 8'h4A, 8'h01}, 32, 6, rd);
        repeat (8) @(posedge ref_clk);
        check("two words", {performance_boost_a, performance_boost_b}, 3'b111);
        acr_serial_ctrl_i.frame({8'h4A, 8'h00, 8'h03, 8'h00}, 20, 6, rd);
        repeat (8) @(posedge ref_clk);
        check("excess bits", {performance_boost_a, performance_boost_b}, 3'b110);
        $display("test multi done");
    endtask : t_multi
    task automatic t_unlisted;
        wr(8'h02, 8'hFF);
        wr(8'h44, 8'hFF);
        wr(8'hFF, 8'hFF);
        check("misc", misc, {6'h00, 1'b0, 1'b1, 1'b0, 2'b11, 1'b0});
        check("cfg", cfgs, 48'h0);
        check("fmt", {gain_code, fmt}, {4'h5, 2'b00, 14'h1234});
        $display("test unlisted done");
    endtask : t_unlisted
    task automatic t_echo;
        pins(1'b1, 1'b1);
        check("flag", overload_or_echo_pin, 1'b1);
        pins(1'b1, 1'b0);
        check("flag", overload_or_echo_pin, 1'b0);
        wr(8'h00, 8'h01);
        rdr(8'h03);
        check("echo 03", rd, 8'h03);
        rdr(8'h3F);
        check("echo 3f", rd, 8'h2A);
        wr(8'h26, 8'h02);
        check("blocked", drv, 2'b01);
        rdr(8'h26);
        check("echo 26", rd, 8'h01);
        pins(1'b1, 1'b1);
        wr(8'h00, 8'h00);
        check("flag back", overload_or_echo_pin, 1'b1);
        pins(1'b1, 1'b0);
        $display("test echo done");
    endtask : t_echo
    task automatic t_soft;
        wr(8'hCF, 8'hFF);
        check("loop cfg", loop_cfg, 8'hBC);
        wr(8'h41, 8'hFF);
        wr(8'h42, 8'hFF);
        wr(8'hBF, 8'hFF);
        wr(8'hDF, 8'hFF);
        check("all cfg", cfgs, 48'hFFC400FCBC30);
        wr(8'h00, 8'h02);
        check("soft", {gain_code, misc}, {4'h5, 12'h000});
        check("soft cfg", cfgs, 48'h0);
        wr(8'h00, 8'h01);
        rdr(8'h40);
        check("echo 40", rd, 8'h00);
        wr(8'h00, 8'h00);
        wr(8'h26, 8'h03);
        check("self clear", drv, 2'b11);
        $display("test soft reset done");
    endtask : t_soft
    task automatic t_hw;
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (10) @(posedge ref_clk);
        check("hw reset", {gain_code, misc}, {4'h5, 12'h000});
        $display("test hw reset done");
    endtask : t_hw

    // main sequence: 115 ns reset pulse, 100 ns before the first frame
    // supplies count as settled long before time zero, serial setup only
    initial begin
        reset = 1'b1;
        format_select_pin = 1'b1;
        over_range = 1'b0;
        conv_data = 14'h1234;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (10) @(posedge ref_clk);
        t_reset;
        t_patterns;
        t_format;
        t_swing;
        t_multi;
        t_unlisted;
        t_echo;
        t_soft;
        t_hw;
        give_verdict;
    end

endmodule : adc_config_register_bank_bench
